// ===== hw/relay_ctrl_params.svh
// Overview of operation
// - with hold time zero, relay active exactly while compared value at or above threshold
// - with nonzero hold time, relay stays active for the whole hold period
// - each new upward crossing during activity restarts the full hold period
// - hold time zero with auto zeroing enabled never activates that relay
// - any alarm condition, such as range overflow, forces every relay open
// - remote mode relays follow only register writes, ignoring counter and settings, except while an alarm holds them open
// - in threshold modes register writes are ignored, reads return actual relay state
// - remote controlled relays start inactive after power up
// - relay follows a main counter crossing well within 12 ms or 20 ms
// - standard function: relays one and two use main, three and four selected source
// - main scaled value is raw count times multiplier over divider over four plus offset
// - standard function cycles counter counts auto zeroings or relay one switchings
// - totalizer scaled value is raw count times multiplier over divider over four
// - standard function with auto zeroing clears main counter on reaching relay one threshold
// - with standard auto zeroing, relays two to four need threshold not above relay one's, or cycles source
// - marker function: relay one main, relay two cycles, three and four selected source
// - marker function always clears main counter at relay one threshold and counts a marker, except in a cycle where relay two clears the cycles
// - marker cycles value is markers times relay one threshold plus scaled main value
// - marker with auto zeroing: relay two threshold clears only the cycles counter
// - marker without auto zeroing: cycles not cleared, relay two keeps its own settings
// - function select chooses standard or marker function for sources and clearing
// - active mode setting chooses whether active state is closed or open
// - beyond 999999 or below -99999 counting that way stops and alarm is raised
`ifndef RELAY_CTRL_PARAMS_SVH
`define RELAY_CTRL_PARAMS_SVH
// register indexes
`define ADDR_CTRL      4'h0
`define ADDR_MULT      4'h1
`define ADDR_DIV       4'h2
`define ADDR_OFFSET    4'h3
`define ADDR_THR0      4'h4
`define ADDR_HOLD0     4'h8
`define ADDR_REMOTE    4'hC
`define ADDR_STATUS    4'hD
`define ADDR_MAIN      4'hE
`define ADDR_CYCLES    4'hF
// ctrl register fields
`define CTRL_FUNC_BIT  0
`define CTRL_AZ_BIT    1
`define CTRL_CYC_BIT   2
`define CTRL_SRC3_BIT  3
`define CTRL_SRC4_BIT  4
`define CTRL_MODE_LSB  8
// range limits
`define RANGE_HI       32'sd999999
`define RANGE_LO       -32'sd99999
// hold time tick: 0.1 s at 50 MHz
`define CLK_HZ         50000000
`define TICK_NS        100000000
`define TICK_CYCLES    (`TICK_NS / (1000000000 / `CLK_HZ))
`define RESP_MS        12
`define RESP_CYCLES    ((`RESP_MS * 1000000) / (1000000000 / `CLK_HZ))
// reset values
`define MULT_RST       16'h0004
`define DIV_RST        16'h0001
`endif

// ===== hw/relay_ctrl_pkg.sv
package relay_ctrl_pkg;
   // per relay active mode
   typedef enum logic [1:0] {
      MODE_NONE   = 2'b00,
      MODE_CLOSE  = 2'b01,
      MODE_OPEN   = 2'b11,
      MODE_REMOTE = 2'b10
   } relay_mode_t;
   // register port bundle
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [3:0]  addr;
      logic [31:0] wdata;
   } reg_req_t;
   // counting input bundle
   typedef struct packed {
      logic up;
      logic down;
   } count_in_t;
endpackage : relay_ctrl_pkg

// ===== hw/relay_threshold_controller.sv
`timescale 1ns/10ps
`default_nettype none
`include "relay_ctrl_params.svh"
module relay_threshold_controller #(
   parameter int TICK_CYCLES = `TICK_CYCLES
) (
   // clock and reset
   input  wire logic                      i_clk,
   input  wire logic                      i_rst,
   // register port
   input  wire relay_ctrl_pkg::reg_req_t  i_req,
   output var  logic [31:0]               o_rdata,
   // quadrature edge events from the front end, same clock
   input  wire relay_ctrl_pkg::count_in_t i_cnt,
   // outputs
   output var  logic [3:0]                o_relay,
   output var  logic                      o_alarm
);
   import relay_ctrl_pkg::*;

   // the hold timers need a tick period of at least one clock
   if (TICK_CYCLES < 1) begin : g_bad_tick
      $error("TICK_CYCLES must be at least 1");
   end

   logic              func_marker;
   logic              auto_zero;
   logic              cyc_mode;
   logic [3:0]        src_cyc;
   relay_mode_t       mode [4];
   logic [31:0]       ctrl_reg;
   logic [15:0]       scale_multiplier;
   logic [15:0]       div_reg;
   logic signed [31:0] offset_reg;
   logic signed [31:0] threshold [4];
   logic [9:0]        hold_reg [4];
   logic [3:0]        remote_reg;
   logic signed [47:0] raw_main;
   logic [47:0]       raw_total;
   logic signed [31:0] cycles_reg;
   logic [31:0]       markers_reg;
   logic signed [31:0] main_val;
   logic [47:0]       total_val;
   logic signed [31:0] cyc_val;
   logic signed [31:0] cmp_val [4];
   logic [3:0]        reach;
   logic [3:0]        reach_d;
   logic [3:0]        active;
   logic [3:0]        active_d;
   logic              alarm_hi;
   logic              alarm_lo;
   logic              hit_main;
   logic              hit_cyc;
   logic [31:0]       tick_cnt;
   logic              tick;

   assign func_marker = ctrl_reg[`CTRL_FUNC_BIT];
   assign auto_zero   = ctrl_reg[`CTRL_AZ_BIT];
   assign cyc_mode    = ctrl_reg[`CTRL_CYC_BIT];
   assign src_cyc     = {ctrl_reg[`CTRL_SRC4_BIT], ctrl_reg[`CTRL_SRC3_BIT], 1'b0, 1'b0};

   // scaled values; a zero divider is treated as one so software cannot hang the math
   always_comb begin
      logic signed [63:0] prod;
      logic [63:0]        tprod;
      logic signed [63:0] dv;
      prod  = 64'(raw_main) * $signed({48'h0, scale_multiplier});
      tprod = 64'(raw_total) * {48'h0, scale_multiplier};
      dv    = (div_reg == 16'h0) ? 64'sd4 : $signed({46'h0, div_reg, 2'b00});
      main_val  = 32'(prod / dv) + offset_reg;
      total_val = 48'(tprod / 64'(dv));
   end

   // marker function derives cycles from markers; standard keeps its own count
   assign cyc_val = func_marker ? 32'(markers_reg * 32'(threshold[0])) + main_val
                                : cycles_reg;

   // alarm while the main value is outside the display range
   assign alarm_hi = main_val > `RANGE_HI;
   assign alarm_lo = main_val < `RANGE_LO;

   // comparison sources per relay
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_cmp
         always_comb begin
            if (g == 0) cmp_val[g] = main_val;
            else if (g == 1) cmp_val[g] = func_marker ? cyc_val : main_val;
            else cmp_val[g] = src_cyc[g] ? cyc_val : main_val;
            reach[g] = cmp_val[g] >= threshold[g];
         end
      end
   endgenerate

   // clearing requests for the main counter and the cycles count
   assign hit_main = reach[0] && (func_marker || auto_zero);
   assign hit_cyc  = func_marker && auto_zero && reach[1];

   // register writes
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ctrl_reg         <= 32'h0;
         scale_multiplier <= `MULT_RST;
         div_reg          <= `DIV_RST;
         offset_reg       <= 32'sh0;
         remote_reg       <= 4'h0;
         for (int i = 0; i < 4; i++) begin
            threshold[i] <= 32'sh0;
            hold_reg[i]  <= 10'h0;
         end
      end else if (i_req.wr) begin
         case (i_req.addr)
            `ADDR_CTRL:   ctrl_reg <= i_req.wdata;
            `ADDR_MULT:   scale_multiplier <= i_req.wdata[15:0];
            `ADDR_DIV:    div_reg <= i_req.wdata[15:0];
            `ADDR_OFFSET: offset_reg <= i_req.wdata;
            `ADDR_REMOTE: begin
               for (int i = 0; i < 4; i++) begin
                  if (mode[i] == MODE_REMOTE) remote_reg[i] <= i_req.wdata[i];
               end
            end
            default: begin
               if (i_req.addr[3:2] == 2'b01) threshold[i_req.addr[1:0]] <= i_req.wdata;
               if (i_req.addr[3:2] == 2'b10) hold_reg[i_req.addr[1:0]] <= i_req.wdata[9:0];
            end
         endcase
      end
   end

   // relay modes unpacked from the control word
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         mode[i] = relay_mode_t'(ctrl_reg[`CTRL_MODE_LSB + 2*i +: 2]);
      end
   end

   // raw counters; main counting toward the violated limit is inhibited, the total always counts up
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         raw_main  <= 48'sh0;
         raw_total <= 48'h0;
      end else begin
         if (hit_main) raw_main <= 48'sh0;
         else if (i_cnt.up && !i_cnt.down && !alarm_hi) raw_main <= raw_main + 48'sd1;
         else if (i_cnt.down && !i_cnt.up && !alarm_lo) raw_main <= raw_main - 48'sd1;
         if (i_cnt.up && !i_cnt.down) raw_total <= raw_total + 48'h1;
      end
   end

   // cycles counter and marker count
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cycles_reg  <= 32'sh0;
         markers_reg <= 32'h0;
      end else if (func_marker) begin
         cycles_reg <= 32'sh0;
         if (hit_cyc) markers_reg <= 32'h0;
         else if (hit_main) markers_reg <= markers_reg + 32'h1;
      end else begin
         markers_reg <= 32'h0;
         if (cyc_mode ? (active[0] && !active_d[0]) : hit_main)
            cycles_reg <= cycles_reg + 32'sd1;
      end
   end

   // 0.1 s tick for hold timers
   always_ff @(posedge i_clk) begin
      if (i_rst || tick_cnt == 32'(TICK_CYCLES - 1)) tick_cnt <= 32'h0;
      else tick_cnt <= tick_cnt + 32'h1;
   end
   assign tick = tick_cnt == 32'(TICK_CYCLES - 1);

   // per relay activation and hold timing; reaction lands in one cycle, far inside the limit
   generate
      for (g = 0; g < 4; g++) begin : g_relay
         logic [9:0] hold_cnt;
         logic       allowed;
         logic       rise;
         logic       drive;
         assign allowed = !(auto_zero && !func_marker && g != 0 && threshold[g] > threshold[0]
                            && !src_cyc[g]);
         assign rise = reach[g] && !reach_d[g] && allowed;
         always_ff @(posedge i_clk) begin
            if (i_rst) begin
               hold_cnt   <= 10'h0;
               reach_d[g] <= 1'b0;
            end else begin
               reach_d[g] <= reach[g];
               if (rise && hold_reg[g] != 10'h0) hold_cnt <= hold_reg[g];
               else if (tick && hold_cnt != 10'h0) hold_cnt <= hold_cnt - 10'h1;
            end
         end
         always_comb begin
            if (hold_reg[g] == 10'h0)
               active[g] = reach[g] && allowed && !auto_zero;
            else
               active[g] = hold_cnt != 10'h0 || rise;
            if (mode[g] == MODE_REMOTE) drive = remote_reg[g];
            else if (mode[g] == MODE_CLOSE) drive = active[g];
            else if (mode[g] == MODE_OPEN) drive = !active[g];
            else drive = 1'b0;
         end
         always_ff @(posedge i_clk) begin
            if (i_rst) o_relay[g] <= 1'b0;
            else o_relay[g] <= drive && !(alarm_hi || alarm_lo);
         end
      end
   endgenerate

   // delayed activity, to find switchings of relay one
   always_ff @(posedge i_clk) begin
      if (i_rst) active_d <= 4'h0;
      else active_d <= active;
   end

   // registered alarm, so the pin never shows a compare glitch
   always_ff @(posedge i_clk) begin
      if (i_rst) o_alarm <= 1'b0;
      else o_alarm <= alarm_hi || alarm_lo;
   end

   // read data, one cycle after the strobe
   always_ff @(posedge i_clk) begin
      if (i_rst) o_rdata <= 32'h0;
      else if (i_req.rd) begin
         case (i_req.addr)
            `ADDR_CTRL:   o_rdata <= ctrl_reg;
            `ADDR_MULT:   o_rdata <= {16'h0, scale_multiplier};
            `ADDR_DIV:    o_rdata <= {16'h0, div_reg};
            `ADDR_OFFSET: o_rdata <= offset_reg;
            `ADDR_REMOTE: o_rdata <= {28'h0, o_relay};
            `ADDR_STATUS: o_rdata <= {total_val[31:0]};
            `ADDR_MAIN:   o_rdata <= main_val;
            `ADDR_CYCLES: o_rdata <= cyc_val;
            default: begin
               if (i_req.addr[3:2] == 2'b01) o_rdata <= threshold[i_req.addr[1:0]];
               else o_rdata <= {22'h0, hold_reg[i_req.addr[1:0]]};
            end
         endcase
      end else o_rdata <= 32'h0;
   end

   // assertions
   alarm_opens_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (alarm_hi || alarm_lo) |=> o_relay == 4'h0) else $error("relay not open on alarm");
   remote_follow_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (mode[2] == MODE_REMOTE && !alarm_hi && !alarm_lo) |=> o_relay[2] == $past(remote_reg[2]))
      else $error("remote relay mismatch");
   remote_ignore_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_req.wr && i_req.addr == `ADDR_REMOTE && mode[1] != MODE_REMOTE) |=> $stable(remote_reg[1]))
      else $error("remote write took effect");
   zero_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (hold_reg[2] == 10'h0 && !auto_zero && !func_marker && src_cyc[2] == 1'b0) |-> active[2] == reach[2])
      else $error("zero hold relay mismatch");
   az_zero_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (auto_zero && hold_reg[0] == 10'h0) |-> !active[0]) else $error("relay active with auto zero");
   hold_restart_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (g_relay[0].rise && hold_reg[0] != 10'h0) |=> g_relay[0].hold_cnt == $past(hold_reg[0]))
      else $error("hold not restarted");
   main_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (reach[0] && func_marker) |=> raw_main == 48'sh0) else $error("main not cleared");
   hi_inhibit_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (alarm_hi && !hit_main) |=> raw_main <= $past(raw_main)) else $error("count past high limit");
   marker_cyc_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (func_marker && hit_cyc) |=> markers_reg == 32'h0) else $error("cycles not cleared");

   // alarm pin mirrors the range check one cycle later
   alarm_flag_a: assert property (@(posedge i_clk) disable iff (i_rst)
      1'b1 |=> o_alarm == $past(alarm_hi || alarm_lo))
      else $error("alarm pin mismatch");

   // no counting further below the low limit
   lo_inhibit_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (alarm_lo && !hit_main) |=> raw_main >= $past(raw_main))
      else $error("count past low limit");

   // close mode drives the contact closed while active
   close_mode_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (mode[0] == MODE_CLOSE && !alarm_hi && !alarm_lo) |=> o_relay[0] == $past(active[0]))
      else $error("close mode mismatch");

   // open mode drives the contact open while active
   open_mode_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (mode[1] == MODE_OPEN && !alarm_hi && !alarm_lo) |=> o_relay[1] == !$past(active[1]))
      else $error("open mode mismatch");

   // an unused relay stays open
   none_mode_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (mode[3] == MODE_NONE) |=> !o_relay[3])
      else $error("unused relay closed");

   // remote bits come up inactive
   remote_reset_a: assert property (@(posedge i_clk)
      i_rst |=> remote_reg == 4'h0)
      else $error("remote bits not cleared");

   // every output is quiet after reset
   relay_reset_a: assert property (@(posedge i_clk)
      i_rst |=> o_relay == 4'h0 && !o_alarm && o_rdata == 32'h0)
      else $error("outputs not quiet in reset");

   // standard function: relay two compares the main value
   std_source_a: assert property (@(posedge i_clk) disable iff (i_rst)
      !func_marker |-> cmp_val[1] == main_val)
      else $error("relay two source wrong");

   // marker function: relay two compares the cycles value
   marker_source_a: assert property (@(posedge i_clk) disable iff (i_rst)
      func_marker |-> cmp_val[1] == cyc_val)
      else $error("relay two marker source wrong");

   // relay four follows cycles when selected
   src_select_a: assert property (@(posedge i_clk) disable iff (i_rst)
      src_cyc[3] |-> cmp_val[3] == cyc_val)
      else $error("relay four source wrong");

   // relay three follows main when not selected
   src_main_a: assert property (@(posedge i_clk) disable iff (i_rst)
      !src_cyc[2] |-> cmp_val[2] == main_val)
      else $error("relay three source wrong");

   // standard auto zeroing clears the main counter
   std_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (!func_marker && auto_zero && reach[0]) |=> raw_main == 48'sh0)
      else $error("main not auto zeroed");

   // cycles count one per auto zeroing
   cyc_count_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (!func_marker && !cyc_mode && hit_main) |=> cycles_reg == $past(cycles_reg) + 32'sd1)
      else $error("zeroing not counted");

   // cycles hold still without a zeroing
   cyc_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (!func_marker && !cyc_mode && !hit_main) |=> $stable(cycles_reg))
      else $error("cycles moved without zeroing");

   // cycles count one per switching of relay one
   switch_count_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (!func_marker && cyc_mode && active[0] && !active_d[0]) |=> cycles_reg == $past(cycles_reg) + 32'sd1)
      else $error("switching not counted");

   // each marker clearing adds one marker, except when the cycles clear in the same cycle
   marker_count_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (func_marker && hit_main && !hit_cyc) |=> markers_reg == $past(markers_reg) + 32'h1)
      else $error("marker not counted");

   // with no markers the length is the main value
   marker_len_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (func_marker && markers_reg == 32'h0) |-> cyc_val == main_val)
      else $error("length without markers wrong");

   // clearing the cycles leaves the main counter alone
   marker_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (hit_cyc && !reach[0] && !i_cnt.up && !i_cnt.down) |=> raw_main == $past(raw_main))
      else $error("main touched by cycles clear");

   // without auto zero the markers are kept
   no_az_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (func_marker && !auto_zero && !hit_main) |=> markers_reg == $past(markers_reg))
      else $error("cycles cleared without auto zero");

   // higher thresholds cannot fire under standard auto zero
   allowed_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (auto_zero && !func_marker && threshold[1] > threshold[0] && !src_cyc[1]) |-> !g_relay[1].rise)
      else $error("relay two fired above relay one");

   // a running hold keeps the relay active
   hold_active_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (hold_reg[0] != 10'h0 && g_relay[0].hold_cnt != 10'h0) |-> active[0])
      else $error("relay dropped during hold");

   // the hold count only moves on a tick or a crossing
   hold_count_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (!g_relay[0].rise && !tick) |=> $stable(g_relay[0].hold_cnt))
      else $error("hold count moved");

   // read data is zero outside the answer cycle
   rdata_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
      !i_req.rd |=> o_rdata == 32'h0)
      else $error("read data not idle");

   // reading the remote index shows the driven relays
   remote_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_req.rd && i_req.addr == `ADDR_REMOTE) |=> o_rdata == {28'h0, $past(o_relay)})
      else $error("remote read mismatch");
endmodule : relay_threshold_controller
`default_nettype wire

// ===== sim/relay_machinery.sv
`timescale 1ns/10ps
`default_nettype none
// far-side machinery: a marker on relay one, counted per closure of its contact
module relay_machinery (
   // clock
   input  wire logic       i_clk,
   // relay contacts from the controller, 1 = closed
   input  wire logic [3:0] i_relay,
   // marker strokes seen so far, wraps silently
   output var  logic [7:0] o_marks
);
   logic last_reg;
   initial o_marks = 8'h00;
   initial last_reg = 1'b0;
   // a stroke is one closing edge; the machine has no reset of its own, like a real one
   always @(posedge i_clk) begin
      last_reg <= i_relay[0];
      if (i_relay[0] && !last_reg) o_marks <= o_marks + 8'h01;
   end
endmodule : relay_machinery
`default_nettype wire

// ===== sim/test_relay_threshold_controller.sv
`timescale 1ns/10ps
`default_nettype none
`include "relay_ctrl_params.svh"
`define CMP(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module test_relay_threshold_controller;
   import relay_ctrl_pkg::*;
   logic        i_clk = 1'b0;
   logic        i_rst = 1'b1;
   reg_req_t    i_req = '0;
   count_in_t   i_cnt = '0;
   logic [31:0] o_rdata;
   logic [3:0]  o_relay;
   logic        o_alarm;
   logic [7:0]  marks;
   logic        rd_d = 1'b0;
   logic [36:0] notes [$];
   logic [36:0] exp_note;
   logic [7:0]  m0;
   int          errors = 0;
   int          compares = 0;
   int          thr;
   relay_threshold_controller #(.TICK_CYCLES(4)) u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req),
      .o_rdata(o_rdata), .i_cnt(i_cnt), .o_relay(o_relay), .o_alarm(o_alarm));
   relay_machinery u_far (.i_clk(i_clk), .i_relay(o_relay), .o_marks(marks));
   // 50 MHz clock
   always #10 i_clk = ~i_clk;
   task end_of_test;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   task rst(input int n);
      @(posedge i_clk) i_rst <= 1'b1;
      repeat (n) @(posedge i_clk);
      i_rst <= 1'b0;
   endtask : rst
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk) i_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge i_clk) i_req <= '0;
   endtask : wr
   // read one index and note alarm, relays and read data expected in the answer cycle
   task chk(input logic [3:0] a, input logic al, input logic [3:0] rl, input logic [31:0] d);
      @(posedge i_clk) i_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      notes.push_back({al, rl, d});
      @(posedge i_clk) i_req <= '0;
   endtask : chk
   task pulse(input logic up, input int n);
      repeat (n) begin
         @(posedge i_clk) i_cnt <= '{up: up, down: !up};
         @(posedge i_clk) i_cnt <= '0;
      end
   endtask : pulse
   task done(input string name);
      $display("test %s finished, errors %0d", name, errors);
   endtask : done
   // watcher: the answer cycle follows the read strobe, the oldest note is its expectation
   always @(posedge i_clk) begin
      rd_d <= i_req.rd;
      if (rd_d) begin
         exp_note = notes.pop_front();
         `CMP({o_alarm, o_relay, o_rdata}, exp_note)
      end
   end
   // watchdog, well beyond the few hundred cycles the tests need
   initial begin
      #200000;
      errors++;
      end_of_test();
   end
   initial begin
      void'($urandom(32'hBF1F8A0A));
      rst(16);
      chk(`ADDR_MULT, 1'b0, 4'h0, 32'h4);
      chk(`ADDR_DIV, 1'b0, 4'h0, 32'h1);
      chk(`ADDR_REMOTE, 1'b0, 4'h0, 32'h0);
      done("reset");
      // relay0 close, relay1 open, relay2 close fed by the idle cycles counter
      thr = 2 + ($urandom % 4);
      wr(`ADDR_CTRL, 32'h00001D08);
      wr(`ADDR_THR0, 32'(thr));
      wr(`ADDR_THR0 + 4'h1, 32'(thr));
      wr(`ADDR_THR0 + 4'h2, 32'h1);
      m0 = marks;
      pulse(1'b1, thr - 1);
      chk(`ADDR_MAIN, 1'b0, 4'h2, 32'(thr - 1));
      pulse(1'b1, 1);
      chk(`ADDR_MAIN, 1'b0, 4'h1, 32'(thr));
      @(posedge i_clk);
      `CMP(marks - m0, 8'h01)
      pulse(1'b0, 1);
      chk(`ADDR_MAIN, 1'b0, 4'h2, 32'(thr - 1));
      done("threshold");
      wr(`ADDR_REMOTE, 32'hF);
      chk(`ADDR_REMOTE, 1'b0, 4'h2, 32'h2);
      wr(`ADDR_CTRL, 32'h00002D08);
      wr(`ADDR_REMOTE, 32'h4);
      chk(`ADDR_REMOTE, 1'b0, 4'h6, 32'h6);
      done("remote");
      rst(2);
      wr(`ADDR_MULT, 32'h8);
      wr(`ADDR_DIV, 32'h2);
      wr(`ADDR_OFFSET, 32'h5);
      pulse(1'b1, 4);
      chk(`ADDR_MAIN, 1'b0, 4'h0, 32'h9);
      chk(`ADDR_STATUS, 1'b0, 4'h0, 32'h4);
      done("scaling");
      rst(2);
      wr(`ADDR_OFFSET, 32'd999999);
      wr(`ADDR_CTRL, 32'h00000100);
      chk(`ADDR_MAIN, 1'b0, 4'h1, 32'd999999);
      pulse(1'b1, 1);
      chk(`ADDR_MAIN, 1'b1, 4'h0, 32'd1000000);
      pulse(1'b1, 2);
      chk(`ADDR_MAIN, 1'b1, 4'h0, 32'd1000000);
      pulse(1'b0, 1);
      chk(`ADDR_MAIN, 1'b0, 4'h1, 32'd999999);
      done("alarm");
      // hold of 8 ticks of 4 cycles; second crossing 16 cycles in restarts it
      rst(2);
      wr(`ADDR_CTRL, 32'h00000100);
      wr(`ADDR_THR0, 32'h1);
      wr(`ADDR_HOLD0, 32'h8);
      pulse(1'b1, 1);
      pulse(1'b0, 1);
      chk(`ADDR_MAIN, 1'b0, 4'h1, 32'h0);
      repeat (10) @(posedge i_clk);
      pulse(1'b1, 1);
      pulse(1'b0, 1);
      repeat (18) @(posedge i_clk);
      chk(`ADDR_MAIN, 1'b0, 4'h1, 32'h0);
      repeat (30) @(posedge i_clk);
      chk(`ADDR_MAIN, 1'b0, 4'h0, 32'h0);
      done("hold");
      rst(2);
      wr(`ADDR_THR0, 32'h3);
      wr(`ADDR_CTRL, 32'h00000102);
      pulse(1'b1, 3);
      chk(`ADDR_MAIN, 1'b0, 4'h0, 32'h0);
      chk(`ADDR_CYCLES, 1'b0, 4'h0, 32'h1);
      done("auto zero");
      // marker runs, with and without auto zero; relay one threshold kept below relay two's
      for (int az = 1; az >= 0; az--) begin
         rst(2);
         wr(`ADDR_THR0, 32'h3);
         wr(`ADDR_THR0 + 4'h1, 32'h6);
         wr(`ADDR_CTRL, 32'h00000001 | (32'(az) << 1));
         pulse(1'b1, 5);
         chk(`ADDR_MAIN, 1'b0, 4'h0, 32'h2);
         chk(`ADDR_CYCLES, 1'b0, 4'h0, 32'h5);
         pulse(1'b1, 1);
         chk(`ADDR_MAIN, 1'b0, 4'h0, 32'h0);
         chk(`ADDR_CYCLES, 1'b0, 4'h0, az ? 32'h0 : 32'h6);
      end
      done("marker");
      repeat (4) @(posedge i_clk);
      end_of_test();
   end
endmodule : test_relay_threshold_controller
`default_nettype wire
